// [dsof_consts.vh]
// constant definitions for the drive status output flag block
// assumes inclusion by bare name from every design file of this block
`ifndef DSOF_CONSTS_VH
`define DSOF_CONSTS_VH

// output function codes (hexadecimal)
`define DSOF_FN_START      8'h29
`define DSOF_FN_OVERTEMP   8'h2A
`define DSOF_FN_LOWCUR     8'h2B
`define DSOF_FN_READY      8'h32
`define DSOF_FN_FWD        8'h33
`define DSOF_FN_REV        8'h34
`define DSOF_FN_MAJOR      8'h35

// setting limits
`define DSOF_TEMP_MAX      8'hC8
`define DSOF_LOWCUR_MODE_ANY   2'h0
`define DSOF_LOWCUR_MODE_CONST 2'h1
// level is in tenths of rated current: 18 = 1.8 x rated
`define DSOF_LEVEL_MAX_TENTHS  8'h12

// wishbone register byte offsets
`define DSOF_REG_SEL_LO    6'h00
`define DSOF_REG_SEL_HI    6'h04
`define DSOF_REG_SETTINGS  6'h08
`define DSOF_REG_FLAGS     6'h0C
`define DSOF_REG_IRQ_STAT  6'h10
`define DSOF_REG_IRQ_MASK  6'h14

// flag vector bit positions
`define DSOF_BIT_START     0
`define DSOF_BIT_OVERTEMP  1
`define DSOF_BIT_LOWCUR    2
`define DSOF_BIT_READY     3
`define DSOF_BIT_FWD       4
`define DSOF_BIT_REV       5
`define DSOF_BIT_MAJOR     6
`define DSOF_NFLAGS        7

// trip cause codes that count as hardware failures
`define DSOF_TRIP_CT       8'h0A
`define DSOF_TRIP_CPU      8'h0B
`define DSOF_TRIP_GND      8'h0E
`define DSOF_TRIP_FAN      8'h14
`define DSOF_TRIP_GATE     8'h17
`define DSOF_TRIP_MAIN     8'h19

// reset values of settings
`define DSOF_SEL_RESET     8'h00
`define DSOF_TEMP_RESET    8'h5A
`define DSOF_LEVEL_RESET   8'h00

`endif

// [dsof_flag_eval.v]
// combinational evaluation of the seven status flags
// assumes settings already clamped and inputs synchronous to clk
`timescale 1ns/1ps
`include "dsof_consts.vh"
module dsof_flag_eval (
    // run and drive state
    input  wire       run_present,
    input  wire       ready,
    input  wire       drive_fwd,
    input  wire       drive_rev,
    input  wire       const_speed,
    // measurements
    input  wire [7:0] heatsink_temp,
    input  wire [7:0] out_cur_tenths,
    // settings
    input  wire [7:0] overtemp_threshold_setting,
    input  wire [1:0] low_current_mode_setting,
    input  wire [7:0] low_current_level_setting,
    // trip
    input  wire       trip_active,
    input  wire [7:0] trip_cause,
    // flags
    output reg  [6:0] flags
);
    reg hw_trip; // trip cause is one of the hardware causes
    reg lc_gate; // mode-dependent low-current window

    // flags are pure functions of the present inputs
    always @* begin
        case (trip_cause)
            `DSOF_TRIP_CT, `DSOF_TRIP_CPU, `DSOF_TRIP_GND,
            `DSOF_TRIP_FAN, `DSOF_TRIP_GATE, `DSOF_TRIP_MAIN: hw_trip = 1'b1;
            default: hw_trip = 1'b0;
        endcase
        // mode 01 narrows to constant speed; unknown modes behave as 00
        if (low_current_mode_setting == `DSOF_LOWCUR_MODE_CONST) begin
            lc_gate = const_speed;
        end else begin
            lc_gate = drive_fwd | drive_rev;
        end
        flags = 7'h00;
        flags[`DSOF_BIT_START]    = run_present;
        flags[`DSOF_BIT_OVERTEMP] = heatsink_temp > overtemp_threshold_setting;
        flags[`DSOF_BIT_LOWCUR]   = lc_gate &
                                    (out_cur_tenths <= low_current_level_setting);
        flags[`DSOF_BIT_READY]    = ready;
        flags[`DSOF_BIT_FWD]      = drive_fwd;
        flags[`DSOF_BIT_REV]      = drive_rev;
        flags[`DSOF_BIT_MAJOR]    = trip_active & hw_trip;
    end
endmodule

// [dsof_term_mux.v]
// one output terminal: pick a flag by function code, register it
// assumes flag vector laid out per the bit positions in the header
`timescale 1ns/1ps
`include "dsof_consts.vh"
module dsof_term_mux (
    // clock and reset
    input  wire       clk,
    input  wire       arst_n,
    // selection
    input  wire [7:0] func_sel,
    input  wire [6:0] flags,
    // terminal
    output reg        term_out_r
);
    reg term_nxt; // selected flag

    // decode function code; codes outside this block give low
    always @* begin
        case (func_sel)
            `DSOF_FN_START:    term_nxt = flags[`DSOF_BIT_START];
            `DSOF_FN_OVERTEMP: term_nxt = flags[`DSOF_BIT_OVERTEMP];
            `DSOF_FN_LOWCUR:   term_nxt = flags[`DSOF_BIT_LOWCUR];
            `DSOF_FN_READY:    term_nxt = flags[`DSOF_BIT_READY];
            `DSOF_FN_FWD:      term_nxt = flags[`DSOF_BIT_FWD];
            `DSOF_FN_REV:      term_nxt = flags[`DSOF_BIT_REV];
            `DSOF_FN_MAJOR:    term_nxt = flags[`DSOF_BIT_MAJOR];
            default:           term_nxt = 1'b0;
        endcase
    end

    // registered output, cleared by reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            term_out_r <= 1'b0;
        end else begin
            term_out_r <= term_nxt;
        end
    end
endmodule

// [dsof_top.v]
// drive status output flags: run-state tracking, wishbone registers,
// interrupt, and six selectable output terminals
// assumes all inputs synchronous to clk, wishbone classic master
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "dsof_consts.vh"
module dsof_top (
    // clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // run commands and power state
    input  wire        forward_run_command,
    input  wire        reverse_run_command,
    input  wire        main_power_ok,
    input  wire        drive_fault_block,
    input  wire        at_const_speed,
    // measurements
    input  wire [7:0]  heatsink_temp,
    input  wire [7:0]  out_cur_tenths,
    // trip input
    input  wire        trip_active,
    input  wire [7:0]  trip_cause,
    // outputs
    output reg  [4:0]  term_out,
    output reg         alarm_relay_out,
    output reg         drive_fwd_r,
    output reg         drive_rev_r,
    output reg         irq_r
);
    // terminal selectors: 11..15 then alarm relay
    reg  [7:0]  terminal_function_selectors [0:4];
    reg  [7:0]  alarm_relay_function_selector;
    reg  [7:0]  overtemp_threshold_setting;
    reg  [1:0]  low_current_mode_setting;
    reg  [7:0]  low_current_level_setting;
    reg  [1:0]  run_command_source_setting; // stored only, no gating effect
    reg  [6:0]  irq_stat_r;                 // sticky event bits
    reg  [6:0]  irq_mask_r;                 // enable per event
    reg  [6:0]  flags_prev_r;               // for rising-edge events
    wire [6:0]  flags;                      // live flag vector
    wire [5:0]  mux_out;                    // registered terminal values
    reg         ready_nxt;                  // able to accept run commands
    reg         fwd_nxt;
    reg         rev_nxt;
    reg         run_present;
    wire        wb_req;
    wire        wb_wr;
    wire        rd_stat;
    wire [6:0]  rise;
    reg  [31:0] rd_data;
    reg  [7:0]  wr_temp;
    reg  [7:0]  wr_level;
    integer     i;

    // a request is taken once, in the cycle before ack
    assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr   = wb_req & wb_we_i;
    assign rd_stat = wb_req & ~wb_we_i & (wb_adr_i == `DSOF_REG_IRQ_STAT);
    assign rise    = flags & ~flags_prev_r;

    // ready needs main power; control supply alone is not enough
    always @* begin
        ready_nxt   = main_power_ok & ~drive_fault_block & ~trip_active;
        // command counts irrespective of the source setting
        run_present = forward_run_command | reverse_run_command;
        fwd_nxt     = 1'b0;
        rev_nxt     = 1'b0;
        if (ready_nxt) begin
            // conflicting directions stop the motor instead of choosing
            if (forward_run_command & ~reverse_run_command) begin
                fwd_nxt = 1'b1;
            end else if (reverse_run_command & ~forward_run_command) begin
                rev_nxt = 1'b1;
            end
        end
    end

    // drive direction state, registered every cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_fwd_r <= 1'b0;
            drive_rev_r <= 1'b0;
        end else begin
            drive_fwd_r <= fwd_nxt;
            drive_rev_r <= rev_nxt;
        end
    end

    // flag evaluation uses the registered drive state so that flags
    // reflect what the motor is actually doing
    dsof_flag_eval u_eval (
        .run_present                (run_present),
        .ready                      (ready_nxt),
        .drive_fwd                  (drive_fwd_r),
        .drive_rev                  (drive_rev_r),
        .const_speed                (at_const_speed & (drive_fwd_r | drive_rev_r)),
        .heatsink_temp              (heatsink_temp),
        .out_cur_tenths             (out_cur_tenths),
        .overtemp_threshold_setting (overtemp_threshold_setting),
        .low_current_mode_setting   (low_current_mode_setting),
        .low_current_level_setting  (low_current_level_setting),
        .trip_active                (trip_active),
        .trip_cause                 (trip_cause),
        .flags                      (flags)
    );

    // one selectable terminal per output, relay is the last one
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_term
            wire [7:0] sel_w;
            if (g < 5) begin : g_io
                assign sel_w = terminal_function_selectors[g];
            end else begin : g_relay
                assign sel_w = alarm_relay_function_selector;
            end
            dsof_term_mux u_mux (
                .clk        (clk),
                .arst_n     (arst_n),
                .func_sel   (sel_w),
                .flags      (flags),
                .term_out_r (mux_out[g])
            );
        end
    endgenerate

    // copy terminals out through a flop stage owned by the top
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            term_out        <= 5'h0_0;
            alarm_relay_out <= 1'b0;
        end else begin
            term_out        <= mux_out[4:0];
            alarm_relay_out <= mux_out[5];
        end
    end

    // clamp written threshold and level settings to their legal ranges; mode is stored unclamped
    always @* begin
        wr_temp  = wb_dat_i[7:0];
        wr_level = wb_dat_i[15:8];
        if (wr_temp > `DSOF_TEMP_MAX) begin
            wr_temp = `DSOF_TEMP_MAX;
        end
        if (wr_level > `DSOF_LEVEL_MAX_TENTHS) begin
            wr_level = `DSOF_LEVEL_MAX_TENTHS;
        end
    end

    // register writes; a write takes effect in the cycle before ack
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < 5; i = i + 1) begin
                terminal_function_selectors[i] <= `DSOF_SEL_RESET;
            end
            alarm_relay_function_selector <= `DSOF_SEL_RESET;
            overtemp_threshold_setting    <= `DSOF_TEMP_RESET;
            low_current_mode_setting      <= `DSOF_LOWCUR_MODE_ANY;
            low_current_level_setting     <= `DSOF_LEVEL_RESET;
            run_command_source_setting    <= 2'h0;
            irq_mask_r                    <= 7'h00;
        end else if (wb_wr) begin
            case (wb_adr_i)
                `DSOF_REG_SEL_LO: begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (wb_sel_i[i]) begin
                            terminal_function_selectors[i] <= wb_dat_i[8*i +: 8];
                        end
                    end
                end
                `DSOF_REG_SEL_HI: begin
                    if (wb_sel_i[0]) begin
                        terminal_function_selectors[4] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        alarm_relay_function_selector <= wb_dat_i[15:8];
                    end
                end
                `DSOF_REG_SETTINGS: begin
                    if (wb_sel_i[0]) begin
                        overtemp_threshold_setting <= wr_temp;
                    end
                    if (wb_sel_i[1]) begin
                        low_current_level_setting <= wr_level;
                    end
                    if (wb_sel_i[2]) begin
                        low_current_mode_setting   <= wb_dat_i[17:16];
                        run_command_source_setting <= wb_dat_i[21:20];
                    end
                end
                `DSOF_REG_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        irq_mask_r <= wb_dat_i[6:0];
                    end
                end
                default: begin
                    // unmapped or read-only: write dropped, still acked
                end
            endcase
        end
    end

    // read mux; unmapped offsets return zero
    always @* begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            `DSOF_REG_SEL_LO:   rd_data = {terminal_function_selectors[3],
                                           terminal_function_selectors[2],
                                           terminal_function_selectors[1],
                                           terminal_function_selectors[0]};
            `DSOF_REG_SEL_HI:   rd_data = {16'h0000, alarm_relay_function_selector,
                                           terminal_function_selectors[4]};
            `DSOF_REG_SETTINGS: rd_data = {10'h000, run_command_source_setting, 2'h0,
                                           low_current_mode_setting,
                                           low_current_level_setting,
                                           overtemp_threshold_setting};
            `DSOF_REG_FLAGS:    rd_data = {25'h000_0000, flags};
            `DSOF_REG_IRQ_STAT: rd_data = {25'h000_0000, irq_stat_r};
            `DSOF_REG_IRQ_MASK: rd_data = {25'h000_0000, irq_mask_r};
            default:            rd_data = 32'h0000_0000;
        endcase
    end

    // one-wait-state ack, dropped the cycle after it is given
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req & ~wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // sticky status: flag rising edges; a read clears, new events win
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_r   <= 7'h00;
            flags_prev_r <= 7'h00;
            irq_r        <= 1'b0;
        end else begin
            flags_prev_r <= flags;
            if (rd_stat) begin
                irq_stat_r <= rise;
            end else begin
                irq_stat_r <= irq_stat_r | rise;
            end
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule

// [dsof_checker.sv]
// port-level checks for the drive status output flag block
// assumes one clock domain and the bind statement at the foot of this file
`timescale 1ns/1ps
module dsof_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    // register bus handshake
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // run commands and readiness causes
    input wire logic       forward_run_command,
    input wire logic       reverse_run_command,
    input wire logic       main_power_ok,
    input wire logic       drive_fault_block,
    input wire logic       trip_active,
    // outputs under watch
    input wire logic [4:0] term_out,
    input wire logic       alarm_relay_out,
    input wire logic       drive_fwd_r,
    input wire logic       drive_rev_r,
    input wire logic       irq_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // commands are only taken while every readiness cause is clear
    wire ready_in = main_power_ok & ~drive_fault_block & ~trip_active;
    wire fwd_only = forward_run_command & ~reverse_run_command;
    wire rev_only = reverse_run_command & ~forward_run_command;

    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer held beyond one cycle");
    a_both_cmd_stop: assert property (forward_run_command && reverse_run_command
        |=> !drive_fwd_r && !drive_rev_r) else $error("drive kept running on both commands");
    a_fwd_drive_on: assert property (fwd_only && ready_in |=> drive_fwd_r && !drive_rev_r)
        else $error("forward drive state wrong");
    a_rev_drive_on: assert property (rev_only && ready_in |=> drive_rev_r && !drive_fwd_r)
        else $error("reverse drive state wrong");
    a_idle_stops_drive: assert property (!forward_run_command && !reverse_run_command
        |=> !drive_fwd_r && !drive_rev_r) else $error("drive running with no command");
    a_unready_ignored: assert property (!ready_in |=> !drive_fwd_r && !drive_rev_r)
        else $error("command taken while not ready");
    a_reset_clears_out: assert property ($rose(arst_n) |-> term_out == 5'h00
        && !alarm_relay_out && !irq_r) else $error("outputs not cleared by reset");

    // main scenarios seen at least once
    c_both_cmds: cover property (forward_run_command && reverse_run_command);
    c_irq_rise: cover property ($rose(irq_r));
    c_relay_rise: cover property ($rose(alarm_relay_out));
endmodule

bind dsof_top dsof_checker u_chk (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .forward_run_command(forward_run_command),
    .reverse_run_command(reverse_run_command), .main_power_ok(main_power_ok),
    .drive_fault_block(drive_fault_block), .trip_active(trip_active), .term_out(term_out),
    .alarm_relay_out(alarm_relay_out), .drive_fwd_r(drive_fwd_r), .drive_rev_r(drive_rev_r),
    .irq_r(irq_r));

// [dsof_ext_ctrl.sv]
// model of the external controller that presents run commands
// assumes the ready flag is routed to a terminal and fed back here
`timescale 1ns/1ps
module dsof_ext_ctrl (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // wishes of the test sequence
    input  wire logic want_fwd,
    input  wire logic want_rev,
    input  wire logic obey,       // low breaks the ready handshake on purpose
    // drive side
    input  wire logic ready_term,
    output logic      fwd_cmd,
    output logic      rev_cmd
);
    // commands go out only while ready is seen or obey is low; the terminal lags, so this is slow
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fwd_cmd <= 1'b0;
            rev_cmd <= 1'b0;
        end else begin
            fwd_cmd <= want_fwd & (ready_term | ~obey);
            rev_cmd <= want_rev & (ready_term | ~obey);
        end
    end
endmodule

// [tb_drive_status_output_flags.sv]
// self-checking bench for the status flag block over its register bus
// assumes terminal 14 carries the ready flag back to the controller model
`timescale 1ns/1ps
`include "dsof_consts.vh"
module tb_drive_status_output_flags;
    // stimulus and observed signals
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [5:0]  wb_adr = 6'h00;
    logic [31:0] wb_dat = 32'h0000_0000, wb_rdata, junk;
    logic        wb_ack, fwd_cmd, rev_cmd, drv_fwd, drv_rev, irq, relay;
    logic        want_fwd = 1'b0, want_rev = 1'b0, obey = 1'b0;
    logic        power_ok = 1'b0, fault_blk = 1'b0, const_spd = 1'b0, trip = 1'b0;
    logic [7:0]  temp = 8'h00, cur = 8'h00, cause = 8'h00;
    logic [4:0]  term;
    logic [7:0]  codes [0:7] = '{8'h0A, 8'h0B, 8'h0E, 8'h14, 8'h17, 8'h19, 8'h0C, 8'h15};
    int          miscompares = 0, comparisons = 0, cycles = 0;
    wire  [5:0]  outs = {relay, term};

    // 125 MHz control clock
    always #4 clk = ~clk;

    dsof_top dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_rdata), .wb_ack_o(wb_ack), .forward_run_command(fwd_cmd),
        .reverse_run_command(rev_cmd), .main_power_ok(power_ok), .drive_fault_block(fault_blk),
        .at_const_speed(const_spd), .heatsink_temp(temp), .out_cur_tenths(cur),
        .trip_active(trip), .trip_cause(cause), .term_out(term), .alarm_relay_out(relay),
        .drive_fwd_r(drv_fwd), .drive_rev_r(drv_rev), .irq_r(irq));

    dsof_ext_ctrl ctrl (.clk(clk), .arst_n(arst_n), .want_fwd(want_fwd), .want_rev(want_rev),
        .obey(obey), .ready_term(term[3]), .fwd_cmd(fwd_cmd), .rev_cmd(rev_cmd));

    // verdict and end of run
    task stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // compare one value and count it
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; the answer is waited for, the timeout cuts a hang
    task wb(input logic we, input logic [5:0] adr, input logic [31:0] dat,
            output logic [31:0] rd);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_rdata;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task wr(input logic [5:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, dat, junk);
    endtask

    task rdchk(input logic [5:0] adr, input logic [31:0] exp);
        logic [31:0] v;
        wb(1'b0, adr, 32'h0000_0000, v);
        check(v, exp);
    endtask

    // let the command, drive and terminal stages all settle, then look mid-cycle
    task step;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test;
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check(outs, 6'h00);
        check(irq, 1'b0);
        rdchk(6'h08, 32'h0000_005A);
        rdchk(6'h18, 32'h0000_0000);
        wr(6'h00, {`DSOF_FN_READY, `DSOF_FN_LOWCUR, `DSOF_FN_OVERTEMP, `DSOF_FN_START});
        wr(6'h04, {16'h0000, `DSOF_FN_MAJOR, `DSOF_FN_FWD});
        rdchk(6'h00, 32'h322B_2A29);
        wr(6'h08, 32'h0000_FFFF);
        rdchk(6'h08, 32'h0000_12C8);
        // command pushed while only the control supply is present
        @(posedge clk);
        want_fwd <= 1'b1;
        step;
        check(outs, 6'h01);
        check(drv_fwd, 1'b0);
        wb(1'b0, 6'h10, 32'h0000_0000, junk);
        wr(6'h14, 32'h0000_0010);
        // main supply on: ready, forward drive, low current while driving
        // the handshake is kept only once ready shows, so the command is not withdrawn
        @(posedge clk);
        power_ok <= 1'b1;
        step;
        @(posedge clk);
        obey <= 1'b1;
        step;
        check(outs, 6'h1D);
        check(irq, 1'b1);
        rdchk(6'h10, 32'h0000_001C);
        step;
        check(irq, 1'b0);
        // constant-speed mode, odd run source, threshold 100 C
        wr(6'h08, 32'h0031_1264);
        step;
        check(outs, 6'h19);
        @(posedge clk);
        const_spd <= 1'b1;
        cur <= 8'h12;
        step;
        check(outs, 6'h1D);
        @(posedge clk);
        cur <= 8'h13;
        temp <= 8'h64;
        step;
        check(outs, 6'h19);
        @(posedge clk);
        temp <= 8'h65;
        step;
        check(outs, 6'h1B);
        // reverse drive, then both directions at once
        wr(6'h04, {16'h0000, `DSOF_FN_MAJOR, `DSOF_FN_REV});
        @(posedge clk);
        want_fwd <= 1'b0;
        want_rev <= 1'b1;
        step;
        check({drv_fwd, drv_rev, outs}, 8'h5B);
        rdchk(6'h0C, 32'h0000_002B);
        @(posedge clk);
        want_fwd <= 1'b1;
        step;
        check({drv_fwd, drv_rev, outs}, 8'h0B);
        @(posedge clk);
        want_fwd <= 1'b0;
        want_rev <= 1'b0;
        fault_blk <= 1'b1;
        step;
        check(outs, 6'h02);
        @(posedge clk);
        fault_blk <= 1'b0;
        // every hardware trip cause and two that do not qualify
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            trip <= 1'b1;
            cause <= codes[i];
            step;
            check(outs, (i < 6) ? 6'h22 : 6'h02);
        end
        @(posedge clk);
        trip <= 1'b0;
        step;
        // masked event stays quiet until its mask bit opens
        wr(6'h14, 32'h0000_0000);
        wb(1'b0, 6'h10, 32'h0000_0000, junk);
        @(posedge clk);
        want_rev <= 1'b1;
        step;
        check(irq, 1'b0);
        wr(6'h14, 32'h0000_0020);
        step;
        check(irq, 1'b1);
        // reset in mid-run while terminals and interrupt are raised
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check(outs, 6'h00);
        check(irq, 1'b0);
        rdchk(6'h00, 32'h0000_0000);
        stop_test;
    end
endmodule
